// File: uart_pkg.sv
// Constants, modes and carriers of the four-mode serial port.
// Assumes one core clock and timer overflow pulses on that clock.
package uart_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL  = 8'h98;
    localparam logic [7:0] ADDR_BUFFER   = 8'h99;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_MP_EN   = 5;
    localparam int BIT_RX_EN   = 4;
    localparam int BIT_TX_NTH  = 3;
    localparam int BIT_RX_NTH  = 2;
    localparam int BIT_TX_DONE = 1;
    localparam int BIT_RX_DONE = 0;
    // ****************************************
    // Timing
    // ****************************************
    localparam int OVERSAMPLE     = 16;
    localparam int FIXED_DIV_SLOW = 64;
    localparam int FIXED_DIV_FAST = 32;
    localparam logic [1:0] FIX_LIM_SLOW = 2'(FIXED_DIV_SLOW / OVERSAMPLE - 1);
    localparam logic [1:0] FIX_LIM_FAST = 2'(FIXED_DIV_FAST / OVERSAMPLE - 1);
    localparam logic [3:0] OS_LAST   = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] OS_MID    = 4'(OVERSAMPLE / 2 - 1);
    localparam int SHIFT_DIV         = 2;
    localparam int SHIFT_BITS        = 8;
    localparam logic [3:0] SHIFT_END = 4'(SHIFT_BITS * SHIFT_DIV - 1);
    localparam logic [3:0] FRAME_8   = 4'ha;
    localparam logic [3:0] FRAME_9   = 4'hb;
    localparam int TX_DEPTH          = 2;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00, MODE_UART8 = 2'b01, MODE_UART9_FIX = 2'b10, MODE_UART9_VAR = 2'b11
    } mode_e;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10
    } rx_state_e;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;
endpackage

// File: serial_port.sv
// Four-mode serial port: shift register and three asynchronous framings.
// Assumes timer overflow pulses and the rate double bit come from core-clock logic.
module serial_port (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       rate_double_bit,
    input  wire logic       t1_overflow,
    input  wire logic       t2_overflow,
    input  wire logic       tx_clock_from_t2,
    input  wire logic       rx_clock_from_t2,
    input  wire logic       t2_run_bit,
    output logic            t2_overflow_flag_set,
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd,
    output logic            tx_buf_ready
);
    // ****************************************
    // Reset release and pin synchroniser
    // ****************************************
    logic [1:0] rst_q;
    logic       rst_n;
    logic [2:0] rxs_q;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn) rst_q <= 2'b00;
        else rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) rxs_q <= 3'b111;
        else rxs_q <= {rxs_q[1:0], rxd_in};
    end
    // Only stages one and two are read; stage zero feeds nothing else
    logic rx_s;
    logic rx_fall;
    assign rx_s    = rxs_q[1];
    assign rx_fall = rxs_q[2] & ~rxs_q[1];

    // ****************************************
    // Register file
    // ****************************************
    uart_pkg::sfr_req_s req;
    logic [7:0]         ctl_q;
    logic [7:0]         rx_hold_q;
    logic [7:0]         rdata_q;
    logic               ti_set;
    logic               ri_set;
    logic               rb8_set;
    logic               rb8_val;
    assign req = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};
    wire ctl_wr = req.wr && req.addr == uart_pkg::ADDR_CONTROL;
    wire buf_wr = req.wr && req.addr == uart_pkg::ADDR_BUFFER;
    uart_pkg::mode_e mode;
    assign mode = uart_pkg::mode_e'(ctl_q[uart_pkg::BIT_MODE_HI:uart_pkg::BIT_MODE_LO]);
    wire mp_en = ctl_q[uart_pkg::BIT_MP_EN];
    wire ren   = ctl_q[uart_pkg::BIT_RX_EN];
    wire tb8   = ctl_q[uart_pkg::BIT_TX_NTH];
    wire ti    = ctl_q[uart_pkg::BIT_TX_DONE];
    wire ri    = ctl_q[uart_pkg::BIT_RX_DONE];
    wire m0    = mode == uart_pkg::MODE_SHIFT;
    wire nine  = ctl_q[uart_pkg::BIT_MODE_HI];
    // Hardware set wins over a software clear in the same cycle
    logic [7:0] ctl_d;
    always_comb
    begin
        ctl_d = ctl_wr ? req.wdata : ctl_q;
        if (ti_set) ctl_d[uart_pkg::BIT_TX_DONE] = 1'b1;
        if (ri_set) ctl_d[uart_pkg::BIT_RX_DONE] = 1'b1;
        if (rb8_set) ctl_d[uart_pkg::BIT_RX_NTH] = rb8_val;
    end
    logic [7:0] rd_mux;
    assign rd_mux = (req.addr == uart_pkg::ADDR_CONTROL) ? ctl_q :
                    (req.addr == uart_pkg::ADDR_BUFFER) ? rx_hold_q : uart_pkg::READ_UNMAPPED;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q   <= uart_pkg::CONTROL_RESET;
            rdata_q <= 8'h00;
        end
        else
        begin
            ctl_q <= ctl_d;
            if (req.rd) rdata_q <= rd_mux;
        end
    end
    assign sfr_rdata = rdata_q;

    // ****************************************
    // Baud ticks
    // ****************************************
    // Oversample tick: timer 1 halves unless doubled, timer 2 passes straight
    function automatic logic sel_tick(input logic use_t2, input logic fixed, input logic fix_t,
                                      input logic t1_t, input logic t2_t);
        sel_tick = fixed ? fix_t : (use_t2 ? t2_t : t1_t);
    endfunction
    logic       t1_half_q;
    logic [1:0] fix_cnt_q;
    logic       t2_flag_q;
    wire [1:0] fix_lim = rate_double_bit ? uart_pkg::FIX_LIM_FAST : uart_pkg::FIX_LIM_SLOW;
    wire fix_tick = fix_cnt_q >= fix_lim;
    wire t1_tick  = t1_overflow && (rate_double_bit || t1_half_q);
    wire fixed    = mode == uart_pkg::MODE_UART9_FIX;
    wire tx_os    = sel_tick(tx_clock_from_t2, fixed, fix_tick, t1_tick, t2_overflow);
    wire rx_os    = sel_tick(rx_clock_from_t2, fixed, fix_tick, t1_tick, t2_overflow);
    wire t2_baud  = (tx_clock_from_t2 || rx_clock_from_t2) && t2_run_bit;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t1_half_q <= 1'b0;
            fix_cnt_q <= 2'b00;
            t2_flag_q <= 1'b0;
        end
        else
        begin
            if (t1_overflow) t1_half_q <= ~t1_half_q;
            fix_cnt_q <= fix_tick ? 2'b00 : fix_cnt_q + 2'b01;
            t2_flag_q <= t2_overflow && !t2_baud;
        end
    end
    assign t2_overflow_flag_set = t2_flag_q;

    // ****************************************
    // Transmit buffer, two entries
    // ****************************************
    // A write into a full buffer is dropped; software should watch tx_buf_ready
    logic [7:0] tbuf_q [uart_pkg::TX_DEPTH];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] cnt_q;
    logic       rdy_q;
    logic       take;
    wire push   = buf_wr && cnt_q != 2'(uart_pkg::TX_DEPTH);
    wire tvalid = cnt_q != 2'b00;
    wire [1:0] cnt_d = cnt_q + 2'(push) - 2'(take);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'b00;
            rdy_q <= 1'b0;
        end
        else
        begin
            if (push) wp_q <= ~wp_q;
            if (take) rp_q <= ~rp_q;
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != 2'(uart_pkg::TX_DEPTH);
        end
    end
    always_ff @(posedge clk)
    begin
        if (push) tbuf_q[wp_q] <= req.wdata;
    end
    assign tx_buf_ready = rdy_q;
    wire [7:0] tword = tbuf_q[rp_q];

    // ****************************************
    // Asynchronous transmitter
    // ****************************************
    logic [3:0]  tos_q;
    logic [10:0] tsh_q;
    logic [3:0]  tbits_q;
    logic        tbusy_q;
    logic        tline_q;
    wire tx_bit   = tx_os && tos_q == uart_pkg::OS_LAST;
    wire tx_take  = !m0 && !tbusy_q && tvalid;
    wire tx_shift = tx_bit && tbits_q != 4'h0;
    wire ti_async = tx_shift && tbits_q == 4'h1;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tos_q   <= 4'h0;
            tsh_q   <= '1;
            tbits_q <= 4'h0;
            tbusy_q <= 1'b0;
            tline_q <= 1'b1;
        end
        else
        begin
            if (tx_os) tos_q <= tos_q + 4'h1;
            if (tx_take)
            begin
                // Shifting waits for the next bit tick
                tsh_q   <= nine ? {1'b1, tb8, tword, 1'b0} : {2'b11, tword, 1'b0};
                tbits_q <= nine ? uart_pkg::FRAME_9 : uart_pkg::FRAME_8;
                tbusy_q <= 1'b1;
            end
            else if (tx_shift)
            begin
                tline_q <= tsh_q[0];
                tsh_q   <= {1'b1, tsh_q[10:1]};
                tbits_q <= tbits_q - 4'h1;
            end
            else if (tx_bit) tbusy_q <= 1'b0;
        end
    end

    // ****************************************
    // Shift-register engine
    // ****************************************
    logic       m0_act_q;
    logic       m0_tx_q;
    logic [3:0] m0_cnt_q;
    logic [7:0] m0_sh_q;
    wire m0_tx_go = m0 && !m0_act_q && tvalid;
    wire m0_rx_go = m0 && !m0_act_q && !tvalid && ren && !ri;
    wire m0_end   = m0_act_q && m0_cnt_q == uart_pkg::SHIFT_END;
    assign take   = tx_take || m0_tx_go;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            m0_act_q <= 1'b0;
            m0_tx_q  <= 1'b0;
            m0_cnt_q <= 4'h0;
            m0_sh_q  <= 8'h00;
        end
        else if (m0_tx_go || m0_rx_go)
        begin
            m0_act_q <= 1'b1;
            m0_tx_q  <= m0_tx_go;
            m0_cnt_q <= 4'h0;
            m0_sh_q  <= m0_tx_go ? tword : 8'h00;
        end
        else if (m0_act_q)
        begin
            // Two core clocks per bit: data leaves with the clock low, shifts on the rise
            m0_cnt_q <= m0_cnt_q + 4'h1;
            if (m0_cnt_q[0]) m0_sh_q <= {rx_s, m0_sh_q[7:1]};
            if (m0_end) m0_act_q <= 1'b0;
        end
    end

    // ****************************************
    // Asynchronous receiver
    // ****************************************
    uart_pkg::rx_state_e rst_st_q;
    logic [3:0]          ros_q;
    logic [3:0]          rbits_q;
    logic [8:0]          rsh_q;
    wire rx_samp  = rx_os && ros_q == uart_pkg::OS_MID;
    wire [3:0] rx_need = nine ? 4'h9 : 4'h8;
    wire rx_final = rst_st_q == uart_pkg::RX_STOP && rx_samp;
    wire rx_nth   = nine ? rsh_q[8] : rx_s;
    wire [7:0] rx_byte = nine ? rsh_q[7:0] : rsh_q[8:1];
    wire rx_ok    = !ri && (!mp_en || rx_nth);
    wire rx_load  = rx_final && rx_ok;
    wire m0_rx_end = m0_end && !m0_tx_q;
    assign ti_set  = ti_async || (m0_end && m0_tx_q);
    assign ri_set  = rx_load || m0_rx_end;
    assign rb8_set = rx_load;
    assign rb8_val = rx_nth;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_st_q <= uart_pkg::RX_IDLE;
            ros_q    <= 4'h0;
            rbits_q  <= 4'h0;
            rsh_q    <= 9'h000;
        end
        else
        begin
            if (rx_os) ros_q <= ros_q + 4'h1;
            case (rst_st_q)
                uart_pkg::RX_IDLE:
                    if (!m0 && ren && rx_fall)
                    begin
                        rst_st_q <= uart_pkg::RX_START;
                        ros_q    <= 4'h0;
                    end
                uart_pkg::RX_START:
                    if (rx_samp)
                    begin
                        rst_st_q <= rx_s ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                        rbits_q  <= 4'h0;
                    end
                uart_pkg::RX_DATA:
                    if (rx_samp)
                    begin
                        rsh_q   <= {rx_s, rsh_q[8:1]};
                        rbits_q <= rbits_q + 4'h1;
                        if (rbits_q == rx_need - 4'h1) rst_st_q <= uart_pkg::RX_STOP;
                    end
                default:
                    if (rx_samp) rst_st_q <= uart_pkg::RX_IDLE;
            endcase
        end
    end
    // A completed byte replaces an unread one only through the accept gate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) rx_hold_q <= 8'h00;
        else if (rx_load) rx_hold_q <= rx_byte;
        else if (m0_rx_end) rx_hold_q <= {rx_s, m0_sh_q[7:1]};
    end

    // ****************************************
    // Pins
    // ****************************************
    logic txd_q;
    logic rxo_q;
    logic rxoe_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txd_q  <= 1'b1;
            rxo_q  <= 1'b1;
            rxoe_q <= 1'b0;
        end
        else
        begin
            txd_q  <= m0 ? (!m0_act_q || m0_cnt_q[0]) : tline_q;
            // Data changes with the falling clock so it is settled at the rise
            rxo_q  <= (m0_act_q && !m0_cnt_q[0]) ? m0_sh_q[0] : rxo_q;
            rxoe_q <= m0 && m0_act_q && m0_tx_q;
        end
    end
    assign txd     = txd_q;
    assign rxd_out = rxo_q;
    assign rxd_oe  = rxoe_q;

    // ****************************************
    // Checks
    // ****************************************
    a_buffer_read: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == uart_pkg::ADDR_BUFFER |=> sfr_rdata == $past(rx_hold_q))
        else $error("buffer read did not return receive holding register");
    a_rx_drop_frame: assert property (@(posedge clk) disable iff (!rst_n)
        rx_final && !rx_ok |=> $stable(rx_hold_q) && ri == $past(ri))
        else $error("rejected frame changed receive state");
    a_rx_store_byte: assert property (@(posedge clk) disable iff (!rst_n)
        rx_load |=> ri && rx_hold_q == $past(rx_byte))
        else $error("accepted frame not stored");
    a_rx_enable_gate: assert property (@(posedge clk) disable iff (!rst_n)
        rst_st_q == uart_pkg::RX_IDLE && !ren |=> rst_st_q == uart_pkg::RX_IDLE)
        else $error("reception began while disabled");
    a_start_abort: assert property (@(posedge clk) disable iff (!rst_n)
        rst_st_q == uart_pkg::RX_START && rx_samp && rx_s |=> rst_st_q == uart_pkg::RX_IDLE)
        else $error("false start bit not abandoned");
    a_shift_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(m0_act_q) |-> ##15 m0_act_q ##1 !m0_act_q)
        else $error("shift transfer not sixteen core clocks");
    a_ti_stop_start: assert property (@(posedge clk) disable iff (!rst_n)
        ti_async |-> ##1 ti ##1 txd)
        else $error("transmit done not raised with stop bit");
    a_frame_ninth: assert property (@(posedge clk) disable iff (!rst_n)
        tx_take && nine |=> tsh_q[9] == $past(tb8) && tbits_q == uart_pkg::FRAME_9)
        else $error("ninth bit or frame length wrong");
    a_t2_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
        t2_baud |=> !t2_overflow_flag_set)
        else $error("timer 2 flag raised in baud duty");
endmodule // serial_port

// File: serial_peer.sv
// Serial peer on the port's pins: sends frames on the receive pin, captures frames from txd.
// Assumes the bench resolves the shared receive pin and sets the bit period in clocks.
module serial_peer (
    input  wire logic clk,
    input  wire logic txd,
    output logic      line
);
    timeunit 1ns;
    timeprecision 100ps;
    int          per = 64;
    int          nbits = 11;
    logic        listen = 1'b1;
    logic [10:0] f;
    logic [10:0] q[$];
    // Idle line rests high, the stop level of an asynchronous link
    initial line = 1'b1;
    task automatic send(input logic [8:0] d, input int nd, input logic stop, input int p);
        line <= 1'b0;
        repeat (p) @(posedge clk);
        for (int i = 0; i < nd; i++)
        begin
            line <= d[i];
            repeat (p) @(posedge clk);
        end
        line <= stop;
        repeat (p) @(posedge clk);
        line <= 1'b1;
        repeat (p) @(posedge clk);
    endtask
    task automatic hold(input logic v);
        line <= v;
    endtask
    task automatic glitch(input int n);
        line <= 1'b0;
        repeat (n) @(posedge clk);
        line <= 1'b1;
        repeat (64) @(posedge clk);
    endtask
    // Stop is not waited out, so a frame that follows at once is still caught
    always @(negedge txd)
    begin
        if (listen)
        begin
            f = 11'h7ff;
            repeat (per / 2) @(posedge clk);
            for (int i = 0; i < nbits; i++)
            begin
                f[i] = txd;
                if (i < nbits - 1)
                    repeat (per) @(posedge clk);
            end
            q.push_back(f);
        end
    end
endmodule // serial_peer

// File: serial_port_uart_four_mode_tb.sv
// Self-checking bench for the four-mode serial port.
// Assumes uart_pkg, serial_port and serial_peer are compiled first.
module serial_port_uart_four_mode_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       rate_double_bit = 1'b0;
    logic       tovf = 1'b0;
    logic       t2_sel = 1'b0;
    logic       t2_run_bit = 1'b0;
    logic [7:0] sfr_rdata;
    logic       t2_overflow_flag_set;
    logic       rxd_out;
    logic       rxd_oe;
    logic       txd;
    logic       tx_buf_ready;
    logic       peer_line;
    wire logic  rxd_pin = rxd_oe ? rxd_out : peer_line;
    int         fails = 0;
    int         n_checks = 0;
    int         cycles = 0;
    logic [7:0] rv;
    serial_port dut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .rate_double_bit(rate_double_bit), .t1_overflow(tovf), .t2_overflow(tovf),
        .tx_clock_from_t2(t2_sel), .rx_clock_from_t2(t2_sel), .t2_run_bit(t2_run_bit),
        .t2_overflow_flag_set(t2_overflow_flag_set), .rxd_in(rxd_pin), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .txd(txd), .tx_buf_ready(tx_buf_ready));
    serial_peer peer (.clk(clk), .txd(txd), .line(peer_line));
    // ****************************************
    // Clock, timer pulses, hang guard
    // ****************************************
    always #5 clk = ~clk;
    // Overflow every second clock: 32 clocks a bit from timer 2 or doubled timer 1, 64 from undoubled timer 1
    always @(posedge clk) tovf <= ~tovf;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        rv = sfr_rdata;
    endtask
    task automatic wait_frames(input int n);
        for (int k = 0; k < 2000 * n && peer.q.size() < n; k++) @(posedge clk);
        check(11'(peer.q.size()), 11'(n));
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(uart_pkg::ADDR_CONTROL);
        check(rv, uart_pkg::CONTROL_RESET);
        rd(uart_pkg::ADDR_BUFFER);
        check(rv, 8'h00);
        rd(8'h5a);
        check(rv, uart_pkg::READ_UNMAPPED);
        check(txd, 1'b1);
        check(rxd_oe, 1'b0);
        wr(8'h98, 8'hbc);
        rd(8'h98);
        check(rv, 8'hbc);
        wr(8'h98, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_tx9();
        logic [8:0] d;
        logic [3:0] hi;
        for (int i = 0; i < 2; i++)
        begin
            d = (i == 0) ? 9'h1a5 : 9'h05a;
            hi = (i == 0) ? 4'h8 : 4'hc;
            wr(8'h98, {hi, d[8], 3'h0});
            wr(8'h99, d[7:0]);
            rd(8'h99);
            check(rv, 8'h00);
            wait_frames(1);
            check(peer.q[0], {1'b1, d, 1'b0});
            peer.q.delete();
            rd(8'h98);
            check(rv, {hi, d[8], 3'h2});
        end
        $display("test tx9 done");
    endtask
    task automatic t_rx9();
        wr(8'h98, 8'hb0);
        peer.send(9'h03c, 9, 1'b1, 64);
        rd(8'h98);
        check(rv, 8'hb0);
        peer.send(9'h1c3, 9, 1'b1, 64);
        rd(8'h98);
        check(rv, 8'hb5);
        peer.send(9'h111, 9, 1'b1, 64);
        rd(8'h99);
        check(rv, 8'hc3);
        wr(8'h98, 8'h90);
        peer.send(9'h0e7, 9, 1'b1, 64);
        rd(8'h98);
        check(rv, 8'h91);
        rd(8'h99);
        check(rv, 8'he7);
        $display("test rx9 done");
    endtask
    task automatic t_rx8();
        @(posedge clk);
        rate_double_bit <= 1'b1;
        wr(8'h98, 8'h70);
        peer.send(9'h096, 8, 1'b0, 32);
        rd(8'h98);
        check(rv, 8'h70);
        peer.send(9'h096, 8, 1'b1, 32);
        rd(8'h98);
        check(rv, 8'h75);
        wr(8'h98, 8'h50);
        peer.glitch(6);
        rd(8'h98);
        check(rv, 8'h50);
        peer.send(9'h05a, 8, 1'b1, 32);
        rd(8'h99);
        check(rv, 8'h5a);
        wr(8'h98, 8'h40);
        peer.send(9'h03c, 8, 1'b1, 32);
        rd(8'h98);
        check(rv, 8'h40);
        $display("test rx8 done");
    endtask
    task automatic t_tx8();
        logic [7:0] sent[$];
        @(posedge clk);
        t2_sel <= 1'b1;
        t2_run_bit <= 1'b1;
        peer.nbits = 10;
        peer.per = 32;
        for (int i = 0; i < 6 && tx_buf_ready === 1'b1; i++)
        begin
            wr(8'h99, 8'(8'h11 * (i + 1)));
            sent.push_back(8'(8'h11 * (i + 1)));
            @(posedge clk);
            #1;
        end
        check(tx_buf_ready, 1'b0);
        wait_frames(sent.size());
        foreach (sent[i]) check(peer.q[i][9:0], {1'b1, sent[i], 1'b0});
        peer.q.delete();
        rd(8'h98);
        check(rv, 8'h42);
        $display("test tx8 done");
    endtask
    task automatic t_shift();
        logic [7:0] bits;
        realtime    t0;
        realtime    t1;
        peer.listen = 1'b0;
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h4b);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge txd);
            bits[i] = rxd_pin;
            check(rxd_oe, 1'b1);
            if (i == 0) t0 = $realtime;
            if (i == 1) t1 = $realtime;
        end
        repeat (4) @(posedge clk);
        check(bits, 8'h4b);
        check(11'(int'(t1 - t0)), 11'h014);
        rd(8'h98);
        check(rv, 8'h02);
        peer.hold(1'b0);
        wr(8'h98, 8'h10);
        repeat (24) @(posedge clk);
        rd(8'h98);
        check(rv, 8'h11);
        rd(8'h99);
        check(rv, 8'h00);
        peer.hold(1'b1);
        $display("test shift done");
    endtask
    task automatic t_t2();
        logic seen;
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            seen |= t2_overflow_flag_set;
        end
        check(seen, 1'b0);
        @(posedge clk);
        t2_run_bit <= 1'b0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            seen |= t2_overflow_flag_set;
        end
        check(seen, 1'b1);
        $display("test t2 done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_tx9();
        t_rx9();
        t_rx8();
        t_tx8();
        t_shift();
        t_t2();
        finish_test();
    end
endmodule // serial_port_uart_four_mode_tb
